// >>> logic/dcam_monitor.v
// Purpose: alarm evaluation, alarm queue and reading memory for digital/totalizer channels
// Assumes: inputs synchronous to mclk; register port with one-cycle read latency
// Notes: sources 0,1 are digital banks, sources 2,3 are totalizers
// Summary of operation
// R1: two alarm numbers, channel on one only
// R2: enabled alarms evaluated always, scan or not
// R3: queue keeps first 20, drops later events
// R4: full queue still lets memory log
// R5: queue emptied by clear, power, reading out
// R6: factory reset, preset keep queue entries
// R7: entry holds reading, absolute time, channel
// R8: each queue read pops one event
// R9: scan logs alarms to large memory, readable
// R10: memory written only while scan runs
// R11: new scan clears memory, not queue
// R12: equal or mismatch masked pattern compare
// R13: zero mask bits are ignored
// R14: compare starts lowest channel, spans width
// R15: totalizer alarms when count reaches limit
// R16: measurement change disables alarms, clears limits
// R17: scaling over limits disables alarms, clears
// R18: scan list drops evaluation, keeps limits; here membership only gates memory logging
// R19: two alarm lines, optional sweep start
// R20: factory reset clears limits; preset keeps
// R21: channel numbers 1101, 1201, 1301, 1302
// R22: line is OR of assigned channels
// R23: latch mode holds until cleared
// R24: track mode follows out-of-limit state
// R25: polarity low or high means alarm
// R26: queue is first-in first-out
`timescale 1ns/10ps
`include "dcam_map.vh"

module dcam_monitor #(
  parameter TICK_CYCLES = (`DCAM_TICK_NS + `DCAM_CLK_NS - 1) / `DCAM_CLK_NS
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [63:0] bank_data,
  input wire [31:0] tot_count0,
  input wire [31:0] tot_count1,
  output reg alarm_number_one,
  output reg alarm_number_two,
  output reg sweep_start
);

  // lane mask for the channel width, always from the lowest channel up
  function [31:0] width_mask;
    input [1:0] w;
    begin
      case (w)
        2'h0: width_mask = 32'h000000FF;
        2'h1: width_mask = 32'h0000FFFF;
        default: width_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  // lowest set bit of a four-bit request vector
  function [1:0] first_set;
    input [3:0] v;
    begin
      if (v[0])
        first_set = 2'h0;
      else if (v[1])
        first_set = 2'h1;
      else if (v[2])
        first_set = 2'h2;
      else
        first_set = 2'h3;
    end
  endfunction

  // channel number of each source
  function [15:0] chan_of;
    input [1:0] s;
    begin
      case (s)
        2'h0: chan_of = `DCAM_CH_BANK1;
        2'h1: chan_of = `DCAM_CH_BANK2;
        2'h2: chan_of = `DCAM_CH_TOT1;
        default: chan_of = `DCAM_CH_TOT2;
      endcase
    end
  endfunction

  reg [6:0] ctrl [0:3]; // per-source control
  reg [31:0] pat [0:1]; // compare_pattern per bank
  reg [31:0] cmask [0:1]; // compare_care_mask per bank
  reg [31:0] upper [0:1]; // count_upper_limit per totalizer
  reg [2:0] outcfg; // track, rising, sweep
  reg [3:0] scan_member; // scan list membership
  reg scanning; // scan in progress
  reg route_err; // sticky rejected routing
  reg q_lost; // sticky discarded event
  reg [31:0] time_now; // absolute time of day
  reg [31:0] tick_cnt; // tick prescaler
  reg [3:0] act_q; // alarm state last cycle
  reg [3:0] pend; // events awaiting logging
  reg [1:0] lat; // latched line state
  reg [31:0] q_rdg [0:`DCAM_Q_DEPTH-1]; // queue readings
  reg [31:0] q_time [0:`DCAM_Q_DEPTH-1]; // queue timestamps
  reg [1:0] q_src [0:`DCAM_Q_DEPTH-1]; // queue sources
  reg [4:0] q_wp; // queue write slot
  reg [4:0] q_rp; // queue read slot
  reg [4:0] q_cnt; // queue occupancy
  reg [15:0] qchan_hold; // channel of last popped entry
  reg [31:0] qtime_hold; // time of last popped entry
  reg [31:0] rm_rdg [0:`DCAM_RM_DEPTH-1]; // reading memory
  reg [2:0] rm_stat [0:`DCAM_RM_DEPTH-1]; // alarm status per reading
  reg [`DCAM_RM_AW-1:0] rm_addr; // read pointer into memory
  reg [`DCAM_RM_AW:0] rm_cnt; // stored readings
  reg [31:0] src_val [0:3]; // present reading per source
  reg [3:0] cond; // out-of-limit per source
  integer i;
  integer j; // loop index of the compare process alone, so each index has one driver

  wire wr_cmd = reg_wr && (reg_addr == `DCAM_A_CMD);
  wire [15:0] cmd = wr_cmd ? reg_wdata[15:0] : 16'h0000;
  wire factory = cmd[`DCAM_K_FACTORY];
  wire scan_go = cmd[`DCAM_K_SCAN_GO];
  wire [1:0] cfg_src = cmd[`DCAM_K_SRCHI:`DCAM_K_SRCLO];
  wire [3:0] act = cond & {ctrl[3][0], ctrl[2][0], ctrl[1][0], ctrl[0][0]};
  wire [3:0] evt = act & ~act_q;
  wire [1:0] sel = first_set(pend);
  wire serve = |pend;
  wire q_full = (q_cnt == `DCAM_Q_DEPTH);
  wire pop = reg_rd && (reg_addr == `DCAM_A_QPOP) && (q_cnt != 5'h00);
  wire push = serve && !q_full; // [R3]
  wire rm_full = (rm_cnt == `DCAM_RM_DEPTH);
  // memory logging ignores queue fullness; only scanning members log
  wire rm_push = serve && scanning && scan_member[sel] && !rm_full; // [R4] [R10] [R18]
  wire [3:0] on1;
  wire [3:0] on2;
  wire [1:0] trk;
  wire [1:0] hit_evt;

  // per-source routing onto alarm numbers
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : route
      assign on1[g] = ctrl[g][`DCAM_C_ROUTE1];
      assign on2[g] = ctrl[g][`DCAM_C_ROUTE2];
    end
  endgenerate
  assign trk = {|(act & on2), |(act & on1)}; // [R22]
  assign hit_evt = {|(evt & on2), |(evt & on1)}; // [R22]

  // pattern compare for banks, upper limit for totalizers; runs regardless of scan
  always @*
  begin
    for (j = 0; j < 4; j = j + 1)
    begin
      src_val[j] = 32'h00000000;
      cond[j] = 1'b0;
    end
    for (j = 0; j < 2; j = j + 1)
    begin
      // lowest channel of the bank sits in the low byte
      src_val[j] = bank_data[j*32 +: 32] & width_mask(ctrl[j][`DCAM_C_WHI:`DCAM_C_WLO]); // [R14]
      // a zero mask bit drops that position from the compare
      cond[j] = (((src_val[j] ^ pat[j]) & cmask[j]) == 32'h00000000) // [R13]
        ^ ctrl[j][`DCAM_C_MISMATCH]; // [R12] [R2]
    end
    src_val[2] = tot_count0;
    src_val[3] = tot_count1;
    cond[2] = (tot_count0 >= upper[0]); // [R15]
    cond[3] = (tot_count1 >= upper[1]); // [R15]
  end

  // configuration registers with their command side effects
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (i = 0; i < 4; i = i + 1)
        ctrl[i] <= `DCAM_CTRL_RST;
      for (i = 0; i < 2; i = i + 1)
      begin
        pat[i] <= 32'h00000000;
        cmask[i] <= 32'h00000000;
        upper[i] <= 32'h00000000;
      end
      outcfg <= `DCAM_OUTCFG_RST;
      scan_member <= 4'h0;
      route_err <= 1'b0;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `DCAM_A_CTRL0, 8'h04, 8'h08, `DCAM_A_CTRL3:
          begin
            // a channel may not sit on both alarm numbers
            if (reg_wdata[`DCAM_C_ROUTE1] && reg_wdata[`DCAM_C_ROUTE2])
              route_err <= 1'b1; // [R1]
            else if (reg_wdata[`DCAM_C_SCALE] && !ctrl[reg_addr[3:2]][`DCAM_C_SCALE])
            begin
              // scaling switched on over existing limits drops them
              ctrl[reg_addr[3:2]] <= {reg_wdata[6:1], 1'b0}; // [R17]
              if (reg_addr[3])
                upper[reg_addr[2]] <= 32'h00000000; // [R17]
              else
              begin
                pat[reg_addr[2]] <= 32'h00000000; // [R17]
                cmask[reg_addr[2]] <= 32'h00000000;
              end
            end
            else
              ctrl[reg_addr[3:2]] <= reg_wdata[6:0]; // [R1]
          end
          `DCAM_A_PAT0: pat[0] <= reg_wdata;
          `DCAM_A_PAT1: pat[1] <= reg_wdata;
          `DCAM_A_MASK0: cmask[0] <= reg_wdata;
          `DCAM_A_MASK1: cmask[1] <= reg_wdata;
          `DCAM_A_UPPER0: upper[0] <= reg_wdata;
          `DCAM_A_UPPER1: upper[1] <= reg_wdata;
          `DCAM_A_OUTCFG: outcfg <= reg_wdata[2:0];
          // membership only gates scan logging; limits stay put
          `DCAM_A_SCANLIST: scan_member <= reg_wdata[3:0]; // [R18]
          default: ;
        endcase
      end
      if (cmd[`DCAM_K_CLS])
        route_err <= 1'b0;
      // measurement configuration change on one source
      if (cmd[`DCAM_K_MEASCFG])
      begin
        ctrl[cfg_src][`DCAM_C_EN] <= 1'b0; // [R16]
        if (cfg_src[1])
          upper[cfg_src[0]] <= 32'h00000000; // [R16]
        else
        begin
          pat[cfg_src[0]] <= 32'h00000000; // [R16]
          cmask[cfg_src[0]] <= 32'h00000000;
        end
      end
      // factory reset: limits and enables gone, slope back to falling;
      // preset and card_reset_cmd deliberately touch nothing here
      if (factory)
      begin
        for (i = 0; i < 4; i = i + 1)
          ctrl[i] <= `DCAM_CTRL_RST; // [R20]
        for (i = 0; i < 2; i = i + 1)
        begin
          pat[i] <= 32'h00000000; // [R20]
          cmask[i] <= 32'h00000000;
          upper[i] <= 32'h00000000;
        end
        outcfg <= `DCAM_OUTCFG_RST; // [R25]
      end
    end
  end

  // absolute time of day, independent of any reading time format
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tick_cnt <= 32'h00000000;
      time_now <= 32'h00000000;
    end
    else if (reg_wr && reg_addr == `DCAM_A_TIME)
    begin
      tick_cnt <= 32'h00000000;
      time_now <= reg_wdata;
    end
    else if (tick_cnt == TICK_CYCLES - 1)
    begin
      tick_cnt <= 32'h00000000;
      time_now <= time_now + 32'h00000001; // [R7]
    end
    else
      tick_cnt <= tick_cnt + 32'h00000001;
  end

  // event edge detect and pending set; a new event wins over service
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      act_q <= 4'h0;
      pend <= 4'h0;
      scanning <= 1'b0;
    end
    else
    begin
      act_q <= act;
      pend <= (pend & ~(serve ? (4'h1 << sel) : 4'h0)) | evt; // [R2]
      if (scan_go)
        scanning <= 1'b1;
      else if (cmd[`DCAM_K_SCAN_STOP])
        scanning <= 1'b0;
    end
  end

  // alarm queue: fifo of first 20 events, emptied only by clear, power, reads
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      q_wp <= 5'h00; // [R5]
      q_rp <= 5'h00;
      q_cnt <= 5'h00;
      q_lost <= 1'b0;
      qchan_hold <= 16'h0000;
      qtime_hold <= 32'h00000000;
    end
    else if (cmd[`DCAM_K_CLS])
    begin
      // clear empties, but an event in the same cycle still lands unless the queue was full
      q_rp <= 5'h00; // [R5]
      q_wp <= push ? 5'h01 : 5'h00;
      q_cnt <= push ? 5'h01 : 5'h00;
      q_lost <= 1'b0;
    end
    else
    begin
      // factory and preset commands never reach this state [R6]
      if (push)
        q_wp <= (q_wp == `DCAM_Q_DEPTH - 1) ? 5'h00 : q_wp + 5'h01; // [R26]
      if (serve && q_full)
        q_lost <= 1'b1; // [R3]
      if (pop)
      begin
        q_rp <= (q_rp == `DCAM_Q_DEPTH - 1) ? 5'h00 : q_rp + 5'h01; // [R8] [R26]
        qchan_hold <= chan_of(q_src[q_rp]); // [R21]
        qtime_hold <= q_time[q_rp];
      end
      if (push && !pop)
        q_cnt <= q_cnt + 5'h01;
      else if (pop && !push)
        q_cnt <= q_cnt - 5'h01; // [R5]
    end
  end

  // queue entry storage: reading, absolute time, source
  always @(posedge mclk)
  begin
    if (push)
    begin
      q_rdg[cmd[`DCAM_K_CLS] ? 5'h00 : q_wp] <= src_val[sel]; // [R7]
      q_time[cmd[`DCAM_K_CLS] ? 5'h00 : q_wp] <= time_now; // [R7]
      q_src[cmd[`DCAM_K_CLS] ? 5'h00 : q_wp] <= sel; // [R7]
    end
  end

  // reading memory fill count; a new scan starts it over
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rm_cnt <= {(`DCAM_RM_AW + 1){1'b0}};
      rm_addr <= {`DCAM_RM_AW{1'b0}};
    end
    else
    begin
      if (scan_go)
        rm_cnt <= {(`DCAM_RM_AW + 1){1'b0}}; // [R11]
      else if (rm_push)
        rm_cnt <= rm_cnt + 1'b1; // [R9]
      if (reg_wr && reg_addr == `DCAM_A_RMADDR)
        rm_addr <= reg_wdata[`DCAM_RM_AW-1:0];
    end
  end

  // reading memory contents; status holds source and alarm number
  always @(posedge mclk)
  begin
    if (rm_push && !scan_go)
    begin
      rm_rdg[rm_cnt[`DCAM_RM_AW-1:0]] <= src_val[sel]; // [R9]
      rm_stat[rm_cnt[`DCAM_RM_AW-1:0]] <= {sel, on2[sel]}; // [R9]
    end
  end

  // alarm lines: latch or track, then polarity; sweep pulse on events pushed into the queue
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      lat <= 2'h0; // [R23]
      alarm_number_one <= 1'b1;
      alarm_number_two <= 1'b1;
      sweep_start <= 1'b0;
    end
    else
    begin
      // set wins over manual clear, scan start or factory reset
      lat <= (lat & ~({cmd[`DCAM_K_CLR2], cmd[`DCAM_K_CLR1]}
        | {2{scan_go | factory}})) | hit_evt; // [R23]
      // rising: high means alarm; falling: low means alarm
      alarm_number_one <= ~outcfg[`DCAM_O_RISING] ^ // [R25]
        (outcfg[`DCAM_O_TRACK] ? trk[0] : lat[0]); // [R24] [R19]
      alarm_number_two <= ~outcfg[`DCAM_O_RISING] ^ // [R25]
        (outcfg[`DCAM_O_TRACK] ? trk[1] : lat[1]); // [R24] [R19]
      sweep_start <= outcfg[`DCAM_O_SWEEP] && push; // [R19]
    end
  end

  // register read port, data one cycle after the strobe
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `DCAM_A_CTRL0, 8'h04, 8'h08, `DCAM_A_CTRL3:
          reg_rdata <= {25'h0000000, ctrl[reg_addr[3:2]]};
        `DCAM_A_PAT0: reg_rdata <= pat[0];
        `DCAM_A_PAT1: reg_rdata <= pat[1];
        `DCAM_A_MASK0: reg_rdata <= cmask[0];
        `DCAM_A_MASK1: reg_rdata <= cmask[1];
        `DCAM_A_UPPER0: reg_rdata <= upper[0];
        `DCAM_A_UPPER1: reg_rdata <= upper[1];
        `DCAM_A_OUTCFG: reg_rdata <= {29'h00000000, outcfg};
        `DCAM_A_SCANLIST: reg_rdata <= {28'h0000000, scan_member};
        `DCAM_A_STATUS: reg_rdata <= {16'h0000, act, q_lost, lat, q_cnt,
          route_err, scanning, q_full, (q_cnt == 5'h00)};
        `DCAM_A_TIME: reg_rdata <= time_now;
        // one read, one event, oldest first
        `DCAM_A_QPOP: reg_rdata <= pop ? q_rdg[q_rp] : 32'h00000000; // [R8]
        `DCAM_A_QCHAN: reg_rdata <= {16'h0000, qchan_hold};
        `DCAM_A_QTIME: reg_rdata <= qtime_hold;
        `DCAM_A_RMADDR: reg_rdata <= {{(32 - `DCAM_RM_AW){1'b0}}, rm_addr};
        // memory reads never disturb the contents, even mid-scan
        `DCAM_A_RMDATA: reg_rdata <= rm_rdg[rm_addr]; // [R9]
        `DCAM_A_RMSTAT: reg_rdata <= {29'h00000000, rm_stat[rm_addr]};
        `DCAM_A_RMCOUNT: reg_rdata <= {{(31 - `DCAM_RM_AW){1'b0}}, rm_cnt};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

endmodule // dcam_monitor

// >>> pkg/dcam_map.vh
// Purpose: register map, field positions, reset values and timing for the alarm monitor
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes: included by the monitor and its checks; definitions only
`ifndef DCAM_MAP_VH
`define DCAM_MAP_VH

// register byte addresses
`define DCAM_A_CTRL0 8'h00
`define DCAM_A_CTRL3 8'h0C
`define DCAM_A_PAT0 8'h10
`define DCAM_A_PAT1 8'h14
`define DCAM_A_MASK0 8'h18
`define DCAM_A_MASK1 8'h1C
`define DCAM_A_UPPER0 8'h20
`define DCAM_A_UPPER1 8'h24
`define DCAM_A_OUTCFG 8'h28
`define DCAM_A_SCANLIST 8'h2C
`define DCAM_A_CMD 8'h30
`define DCAM_A_STATUS 8'h34
`define DCAM_A_TIME 8'h38
`define DCAM_A_QPOP 8'h3C
`define DCAM_A_QCHAN 8'h40
`define DCAM_A_QTIME 8'h44
`define DCAM_A_RMADDR 8'h48
`define DCAM_A_RMDATA 8'h4C
`define DCAM_A_RMSTAT 8'h50
`define DCAM_A_RMCOUNT 8'h54

// per-source control fields
`define DCAM_C_EN 0
`define DCAM_C_ROUTE1 1
`define DCAM_C_ROUTE2 2
`define DCAM_C_MISMATCH 3
`define DCAM_C_WLO 4
`define DCAM_C_WHI 5
`define DCAM_C_SCALE 6
`define DCAM_CTRL_RST 7'h00

// output configuration fields
`define DCAM_O_TRACK 0
`define DCAM_O_RISING 1
`define DCAM_O_SWEEP 2
`define DCAM_OUTCFG_RST 3'h0

// command bits
`define DCAM_K_CLS 0
`define DCAM_K_FACTORY 1
`define DCAM_K_PRESET 2
`define DCAM_K_CARD 3
`define DCAM_K_SCAN_GO 4
`define DCAM_K_SCAN_STOP 5
`define DCAM_K_CLR1 6
`define DCAM_K_CLR2 7
`define DCAM_K_MEASCFG 8
`define DCAM_K_SRCLO 12
`define DCAM_K_SRCHI 13

// channel numbers reported in queue entries
`define DCAM_CH_BANK1 16'h044D
`define DCAM_CH_BANK2 16'h04B1
`define DCAM_CH_TOT1 16'h0515
`define DCAM_CH_TOT2 16'h0516

// alarm queue and reading memory sizes
`define DCAM_Q_DEPTH 20
`define DCAM_RM_DEPTH 524288
`define DCAM_RM_AW 19

// time of day tick, period in ns, clock period in ns
`define DCAM_TICK_NS 1000000
`define DCAM_CLK_NS 4

`endif

// >>> tb/dcam_monitor_props.sv
// Purpose: concurrent checks on the alarm monitor ports
// Assumes: single mclk domain, async active-low reset
// Notes: shadow flags mirror writes so idle line levels can be judged
`timescale 1ns/10ps
`include "dcam_map.vh"
module dcam_monitor_props #(
  parameter TICK_CYCLES = 4
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [63:0] bank_data,
  input wire [31:0] tot_count0,
  input wire [31:0] tot_count1,
  input wire alarm_number_one,
  input wire alarm_number_two,
  input wire sweep_start
);
  reg sh_rising; // slope as last written
  reg sh_sweep; // sweep option as last written
  reg any_en; // sticky: some source was ever enabled
  wire st_rd = reg_rd && reg_addr == `DCAM_A_STATUS; // status read
  wire cmd_wr = reg_wr && reg_addr == `DCAM_A_CMD; // command write

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // shadow of output config; factory reset returns slope to falling
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sh_rising <= 1'b0;
      sh_sweep <= 1'b0;
      any_en <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == `DCAM_A_OUTCFG)
      begin
        sh_rising <= reg_wdata[1];
        sh_sweep <= reg_wdata[2];
      end
      else if (cmd_wr && reg_wdata[1])
        sh_rising <= 1'b0;
      // conservative: never cleared, so idle checks only run early
      if (reg_wr && reg_addr <= `DCAM_A_CTRL3 && reg_wdata[0])
        any_en <= 1'b1;
    end
  end

  reset_idle_a: assert property ($rose(resetn) |-> alarm_number_one && alarm_number_two
    && !sweep_start) else $error("lines not idle after reset");
  idle_lines_a: assert property (!any_en && $past(sh_rising) == sh_rising
    && $past(sh_rising, 2) == sh_rising |-> alarm_number_one == !sh_rising
    && alarm_number_two == !sh_rising) else $error("line shows alarm with no source");
  sweep_gate_a: assert property (sweep_start |-> sh_sweep || $past(sh_sweep))
    else $error("sweep pulse without sweep option");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  qcount_max_a: assert property (st_rd |=> reg_rdata[8:4] <= 5'h14)
    else $error("queue count above limit");
  qfull_flag_a: assert property (st_rd |=> reg_rdata[1] == (reg_rdata[8:4] == 5'h14))
    else $error("full flag disagrees with count");
  qempty_flag_a: assert property (st_rd |=> reg_rdata[0] == (reg_rdata[8:4] == 5'h00))
    else $error("empty flag disagrees with count");
  route_reject_a: assert property ((reg_wr && reg_addr[7:4] == 4'h0
    && reg_addr[1:0] == 2'h0 && reg_wdata[2:1] == 2'h3) ##1 !reg_wr ##1 st_rd |=> reg_rdata[3])
    else $error("double route not flagged");
  cls_empty_a: assert property ((cmd_wr && reg_wdata[0]) ##1 !reg_wr ##1 st_rd
    |=> !reg_rdata[3] && reg_rdata[8:4] <= 5'h04) else $error("clear left queue or flag");

  cover property (sweep_start);
  cover property ($fell(alarm_number_one));
  cover property (reg_rd && reg_addr == `DCAM_A_QPOP);
endmodule // dcam_monitor_props

bind dcam_monitor dcam_monitor_props #(.TICK_CYCLES(TICK_CYCLES)) i_dcam_monitor_props (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bank_data(bank_data),
  .tot_count0(tot_count0), .tot_count1(tot_count1), .alarm_number_one(alarm_number_one),
  .alarm_number_two(alarm_number_two), .sweep_start(sweep_start));

// >>> tb/dcam_line_rx.sv
// Purpose: external receiver on alarm line two and the sweep pulse
// Assumes: receiver is told the slope in use
// Notes: counts alarm onsets and sweep starts for the bench
`timescale 1ns/10ps
module dcam_line_rx (
  input wire mclk,
  input wire resetn,
  input wire rising,
  input wire line_two,
  input wire sweep_start,
  output logic [7:0] onsets,
  output logic [7:0] sweeps
);
  logic was_alarm; // alarm level one cycle ago
  wire alarm_now = (line_two == rising); // high level means alarm only on rising slope

  // count onsets; a slope change can fake one, so callers compare deltas
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      onsets <= 8'h00;
      sweeps <= 8'h00;
      was_alarm <= 1'b0;
    end
    else
    begin
      was_alarm <= alarm_now;
      if (alarm_now && !was_alarm)
        onsets <= onsets + 8'h01;
      if (sweep_start)
        sweeps <= sweeps + 8'h01;
    end
  end
endmodule // dcam_line_rx

// >>> tb/test_digital_channel_alarm_monitor.sv
// Purpose: self-checking bench for the digital channel alarm monitor
// Assumes: short time tick, register port with one-cycle read latency
// Notes: each scenario task drives the block and judges what comes back
`timescale 1ns/10ps
`include "dcam_map.vh"
module test_digital_channel_alarm_monitor;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [63:0] bank_data = 64'h0;
  logic [31:0] tot_count0 = 32'h0;
  logic [31:0] tot_count1 = 32'h0;
  logic rx_rising = 1'b0; // slope told to the receiver
  wire [31:0] reg_rdata;
  wire alarm_number_one;
  wire alarm_number_two;
  wire sweep_start;
  wire [7:0] rx_onsets;
  wire [7:0] rx_sweeps;
  logic [31:0] d; // last read data
  int err_total = 0;
  int n_tests = 0;

  always #2 mclk = ~mclk; // 4 ns period

  dcam_monitor #(.TICK_CYCLES(4)) i_dcam_monitor (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bank_data(bank_data), .tot_count0(tot_count0),
    .tot_count1(tot_count1), .alarm_number_one(alarm_number_one),
    .alarm_number_two(alarm_number_two), .sweep_start(sweep_start));
  dcam_line_rx i_dcam_line_rx (.mclk(mclk), .resetn(resetn), .rising(rx_rising),
    .line_two(alarm_number_two), .sweep_start(sweep_start), .onsets(rx_onsets),
    .sweeps(rx_sweeps));

  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // data is taken in the cycle after the strobe
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d & m, e);
  endtask

  // bounded wait for a line level; running out ends the run
  task wait_line(input logic two, input logic lvl);
    int n;
    #1 n = 0;
    while ((two ? alarm_number_two : alarm_number_one) !== lvl && n < 12)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (n == 12)
    begin
      err_total++;
      final_report;
    end
    chk(two ? alarm_number_two : alarm_number_one, lvl);
  endtask

  task t_reset;
    chk({alarm_number_two, alarm_number_one}, 2'h3);
    rc(`DCAM_A_STATUS, 32'h1FF, 32'h1);
    rc(8'hFC, 32'hFFFFFFFF, 32'h0);
  endtask

  task t_route;
    wr(`DCAM_A_CTRL0, 32'h7);
    rc(`DCAM_A_STATUS, 32'h8, 32'h8);
    rc(`DCAM_A_CTRL0, 32'hFFFFFFFF, 32'h0);
    wr(`DCAM_A_CMD, 32'h1);
    rc(`DCAM_A_STATUS, 32'h8, 32'h0);
  endtask

  task t_pattern;
    wr(`DCAM_A_PAT0, 32'h6);
    wr(`DCAM_A_MASK0, 32'hF);
    @(posedge mclk) bank_data <= 64'hAB00123400000007;
    wr(`DCAM_A_PAT1, 32'h1234);
    wr(`DCAM_A_MASK1, 32'hFFFFFFFF);
    wr(`DCAM_A_CTRL0, 32'h3);
    wr(`DCAM_A_CTRL0 + 8'h04, 32'h1D);
    wr(`DCAM_A_TIME, 32'h12340000);
    idle(4);
    chk({alarm_number_two, alarm_number_one}, 2'h3);
    @(posedge mclk) bank_data[7:0] <= 8'hF6;
    wait_line(1'b0, 1'b0);
    chk(alarm_number_two, 1'b1);
    @(posedge mclk) bank_data[7:0] <= 8'h00;
    idle(4);
    chk(alarm_number_one, 1'b0);
    wr(`DCAM_A_CMD, 32'h40);
    wait_line(1'b0, 1'b1);
    @(posedge mclk) bank_data[63:32] <= 32'hAB001334;
    wait_line(1'b1, 1'b0);
    rc(`DCAM_A_QPOP, 32'hFF, 32'hF6);
    rc(`DCAM_A_QCHAN, 32'hFFFF, 32'h44D);
    rc(`DCAM_A_QTIME, 32'hFFFF0000, 32'h12340000);
    rc(`DCAM_A_QPOP, 32'hFFFF, 32'h1334);
    rc(`DCAM_A_QCHAN, 32'hFFFF, 32'h4B1);
    rc(`DCAM_A_STATUS, 32'h1F1, 32'h1);
    rc(`DCAM_A_QPOP, 32'hFFFFFFFF, 32'h0);
    wr(`DCAM_A_CTRL0 + 8'h04, 32'h0);
    wr(`DCAM_A_CMD, 32'hC0);
  endtask

  task t_total;
    logic [7:0] o;
    rx_rising <= 1'b1;
    wr(`DCAM_A_OUTCFG, 32'h7);
    wait_line(1'b1, 1'b0);
    wr(`DCAM_A_UPPER0, 32'h64);
    @(posedge mclk) tot_count0 <= 32'h63;
    wr(`DCAM_A_CTRL0 + 8'h08, 32'h5);
    idle(4);
    o = rx_onsets;
    chk(alarm_number_two, 1'b0);
    @(posedge mclk) tot_count0 <= 32'h64;
    wait_line(1'b1, 1'b1);
    @(posedge mclk) tot_count0 <= 32'h32;
    wait_line(1'b1, 1'b0);
    chk(rx_onsets, o + 8'h01);
    chk(rx_sweeps, 8'h01);
    rc(`DCAM_A_QPOP, 32'hFFFFFFFF, 32'h64);
    rc(`DCAM_A_QCHAN, 32'hFFFF, 32'h515);
    wr(`DCAM_A_CTRL0 + 8'h08, 32'h0);
    wr(`DCAM_A_OUTCFG, 32'h0);
    rx_rising <= 1'b0;
  endtask

  // overflow the queue while a scan logs every event
  task t_full;
    wr(`DCAM_A_PAT0, 32'h1);
    wr(`DCAM_A_MASK0, 32'h1);
    wr(`DCAM_A_SCANLIST, 32'h1);
    wr(`DCAM_A_CMD, 32'h10);
    for (int k = 0; k < 25; k++)
    begin
      @(posedge mclk) bank_data[31:0] <= 2 * k;
      idle(3);
      @(posedge mclk) bank_data[31:0] <= 2 * k + 1;
      idle(3);
    end
    rc(`DCAM_A_STATUS, 32'h9FF, 32'h946);
    rc(`DCAM_A_RMCOUNT, 32'hFFFFFFFF, 32'h19);
    wr(`DCAM_A_RMADDR, 32'h0);
    rc(`DCAM_A_RMDATA, 32'hFF, 32'h1);
    rc(`DCAM_A_RMSTAT, 32'h7, 32'h0);
    wr(`DCAM_A_CMD, 32'h20);
    @(posedge mclk) bank_data[31:0] <= 32'h32;
    idle(3);
    @(posedge mclk) bank_data[31:0] <= 32'h33;
    idle(4);
    rc(`DCAM_A_RMCOUNT, 32'hFFFFFFFF, 32'h19);
    wr(`DCAM_A_CMD, 32'h4);
    rc(`DCAM_A_CTRL0, 32'hFF, 32'h3);
    wr(`DCAM_A_CMD, 32'h2);
    rc(`DCAM_A_CTRL0, 32'h1, 32'h0);
    rc(`DCAM_A_MASK0, 32'hFFFFFFFF, 32'h0);
    rc(`DCAM_A_STATUS, 32'h1F0, 32'h140);
    wr(`DCAM_A_CMD, 32'h10);
    rc(`DCAM_A_RMCOUNT, 32'hFFFFFFFF, 32'h0);
    rc(`DCAM_A_STATUS, 32'h1F0, 32'h140);
    wr(`DCAM_A_CMD, 32'h20);
    rc(`DCAM_A_QPOP, 32'hFF, 32'h1);
    repeat (18) rc(`DCAM_A_QCHAN, 32'hFFFF, 32'h44D);
    rc(`DCAM_A_QPOP, 32'hFF, 32'h3);
  endtask

  task t_cfg;
    @(posedge mclk) tot_count0 <= 32'h0;
    wr(`DCAM_A_UPPER0, 32'h7);
    wr(`DCAM_A_CTRL0 + 8'h08, 32'h5);
    wr(`DCAM_A_SCANLIST, 32'h0);
    rc(`DCAM_A_UPPER0, 32'hFFFFFFFF, 32'h7);
    wr(`DCAM_A_CMD, 32'h2100);
    rc(`DCAM_A_CTRL0 + 8'h08, 32'h1, 32'h0);
    rc(`DCAM_A_UPPER0, 32'hFFFFFFFF, 32'h0);
    wr(`DCAM_A_UPPER1, 32'h9);
    wr(`DCAM_A_CTRL3, 32'h3);
    wr(`DCAM_A_CTRL3, 32'h43);
    rc(`DCAM_A_CTRL3, 32'h1, 32'h0);
    rc(`DCAM_A_UPPER1, 32'hFFFFFFFF, 32'h0);
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    idle(1);
    t_reset;
    t_route;
    t_pattern;
    t_total;
    t_full;
    t_cfg;
    final_report;
  end
endmodule // test_digital_channel_alarm_monitor
